// >>> rcpm_regs.svh
// Purpose: offsets, fields, reset values and timing of the reference clock and power block
// Assumes: 16-bit register port, word offsets
// Notes:   included by the design, the checker and the bench
`ifndef RCPM_REGS_SVH
`define RCPM_REGS_SVH

`define RCPM_ADDR_REFOCTL     4'h0
`define RCPM_ADDR_RESETCTL    4'h1
`define RCPM_ADDR_PWRCFG      4'h2
`define RCPM_ADDR_STATUS      4'h3

`define RCPM_REFOCTL_RESET    16'h0000
`define RCPM_REFOCTL_MASK     16'hbf00
`define RCPM_RESETCTL_RESET   16'h0000
`define RCPM_RESETCTL_MASK    16'h0100
`define RCPM_PWRCFG_RESET     16'h0000
`define RCPM_PWRCFG_MASK      16'h001f

`define RCPM_BIT_REF_EN       15
`define RCPM_BIT_REF_SLP      13
`define RCPM_BIT_REF_SEL      12
`define RCPM_DIV_HI           11
`define RCPM_DIV_LO           8
`define RCPM_BIT_VREG_STBY    8
`define RCPM_BIT_POSC_KEEP    0
`define RCPM_BIT_PRIMARY_MODE 1
`define RCPM_BIT_WDT_EN       2
`define RCPM_BIT_FAIL_SAFE_CLOCK_MONITOR_EN      3
`define RCPM_BIT_CFG_LOCK     4

`define RCPM_OP_SLEEP         1'b0
`define RCPM_OP_IDLE          1'b1

`define RCPM_TVREG_US         10
`define RCPM_CLK_MHZ          20

`endif

// >>> rcpm_pkg.sv
// Purpose: types for the reference clock and power block
// Assumes: header holds the numbers
// Notes:   power state enumeration
package rcpm_pkg;
    typedef enum logic [2:0] {
        RUN,
        ENTER_SLEEP,
        SLEEP,
        ENTER_IDLE,
        IDLE,
        WAKE_REG
    } rcpm_pwr_state_type;
endpackage : rcpm_pkg

// >>> rcpm_refclk_power.sv
// Purpose: divided reference clock output and sleep/idle power sequencing
// Assumes: base clocks come in as pins, sampled on ref_clk
// Notes:   state changes follow the power save request port
// Notes on behaviour
// - enable bit drives divided clock on pin
// - divisor field divides by two to the value
// - source bit picks primary oscillator or system clock
// - run-in-sleep keeps output in sleep
// - sleep stops crystal unless primary or kept
// - operand zero sleeps, one idles
// - sleep stops clocks, cpu and peripherals
// - idle halts cpu, peripherals keep running
// - watchdog cleared on sleep and idle entry
// - rc oscillator kept for watchdog or monitor
// - fail-safe monitor off during sleep
// - wake on interrupt, reset or watchdog timeout
// - sleep wake resumes the same clock source
// - idle wake restarts cpu at once
// - regulator standby adds start delay to wake
// - coincident interrupt wakes after entry completes
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps

`include "rcpm_regs.svh"

module rcpm_refclk_power #(
    parameter int DIV_W    = 16,
    parameter int TVREG_CY = `RCPM_TVREG_US * `RCPM_CLK_MHZ
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // base clocks from pins
    input  wire logic        sys_clk_in,
    input  wire logic        primary_osc_in,
    // power save request, wake events and oscillator select
    input  wire logic        power_save_instruction,
    input  wire logic        power_save_operand,
    input  wire logic        irq_wake,
    input  wire logic        wdt_timeout,
    input  wire logic [2:0]  new_oscillator_select,
    // outputs
    output logic             ref_clock_pin,
    output logic             ref_clock_pin_oe,
    output logic             sys_clk_run,
    output logic             primary_osc_run,
    output logic             low_power_rc_oscillator_run,
    output logic             fail_safe_clock_monitor_active,
    output logic             cpu_run,
    output logic             periph_run,
    output logic             wdt_clear,
    output logic             vreg_standby,
    output logic             cpu_resume,
    output logic      [2:0]  active_osc
);
    localparam int TVW = $clog2(TVREG_CY + 1);

    logic                    rst_s1;
    logic                    rst_n;
    logic [15:0]             ref_out_control_reg;
    logic [15:0]             reset_control_reg;
    logic [15:0]             pwr_cfg;
    logic [2:0]              osc_sel;
    logic [2:0]              sleep_osc;
    logic [2:0]              sys_sync;
    logic [2:0]              posc_sync;
    logic                    base_prev;
    logic                    base_now;
    logic                    base_edge;
    logic [DIV_W-1:0]        div_cnt;
    logic [DIV_W-1:0]        div_mask;
    logic [3:0]              ref_out_divisor;
    logic                    ref_out_enable;
    logic                    ref_out_run_in_sleep;
    logic                    ref_out_source_select;
    logic                    in_sleep;
    logic                    wake_evt;
    logic                    wake_pend;
    logic [TVW-1:0]          tvreg_cnt;
    rcpm_pkg::rcpm_pwr_state_type state;

    assign ref_out_enable        = ref_out_control_reg[`RCPM_BIT_REF_EN];
    assign ref_out_run_in_sleep  = ref_out_control_reg[`RCPM_BIT_REF_SLP];
    assign ref_out_source_select = ref_out_control_reg[`RCPM_BIT_REF_SEL];
    assign ref_out_divisor       = ref_out_control_reg[`RCPM_DIV_HI:`RCPM_DIV_LO];
    assign in_sleep              = (state == rcpm_pkg::SLEEP);
    assign wake_evt              = irq_wake | wdt_timeout;

    // reset release
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_out_control_reg <= `RCPM_REFOCTL_RESET;
            reset_control_reg   <= `RCPM_RESETCTL_RESET;
            pwr_cfg             <= `RCPM_PWRCFG_RESET;
            osc_sel             <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `RCPM_ADDR_REFOCTL:  ref_out_control_reg <= reg_wdata & `RCPM_REFOCTL_MASK;
                `RCPM_ADDR_RESETCTL: reset_control_reg   <= reg_wdata & `RCPM_RESETCTL_MASK;
                `RCPM_ADDR_PWRCFG:   pwr_cfg             <= reg_wdata & `RCPM_PWRCFG_MASK;
                default: ;
            endcase
        end else if (!pwr_cfg[`RCPM_BIT_CFG_LOCK] && state == rcpm_pkg::RUN) begin
            osc_sel <= new_oscillator_select;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `RCPM_ADDR_REFOCTL:  reg_rdata <= ref_out_control_reg;
                `RCPM_ADDR_RESETCTL: reg_rdata <= reset_control_reg;
                `RCPM_ADDR_PWRCFG:   reg_rdata <= pwr_cfg;
                `RCPM_ADDR_STATUS:   reg_rdata <= {7'h00, cpu_run, in_sleep,
                                                   (state == rcpm_pkg::IDLE),
                                                   vreg_standby, low_power_rc_oscillator_run, fail_safe_clock_monitor_active,
                                                   active_osc};
                default:             reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // pin synchronisers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_sync  <= 3'h0;
            posc_sync <= 3'h0;
            base_prev <= 1'b0;
        end else begin
            sys_sync  <= {sys_sync[1:0], sys_clk_in};
            posc_sync <= {posc_sync[1:0], primary_osc_in};
            base_prev <= base_now;
        end
    end

    // base follows any switch of the system clock when not primary
    assign base_now  = ref_out_source_select ? posc_sync[2] : sys_sync[2];
    assign base_edge = base_now & ~base_prev;

    // output toggles and count clears when masked count reaches half the mask; divisor 0 passes base through
    assign div_mask = DIV_W'((32'h1 << ref_out_divisor) - 32'h1);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt          <= '0;
            ref_clock_pin    <= 1'b0;
            ref_clock_pin_oe <= 1'b0;
        end else if (!ref_out_enable || (in_sleep && !ref_out_run_in_sleep)) begin
            div_cnt          <= '0;
            ref_clock_pin    <= 1'b0;
            ref_clock_pin_oe <= ref_out_enable;
        end else begin
            ref_clock_pin_oe <= 1'b1;
            if (ref_out_divisor == 4'h0) begin
                ref_clock_pin <= base_now;
            end else if (base_edge) begin
                if ((div_cnt & div_mask) == (div_mask >> 1)) begin
                    ref_clock_pin <= ~ref_clock_pin;
                    div_cnt       <= '0;
                end else begin
                    div_cnt <= div_cnt + DIV_W'(1);
                end
            end
        end
    end

    // power state sequencing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= rcpm_pkg::RUN;
            wake_pend <= 1'b0;
            tvreg_cnt <= '0;
            sleep_osc <= 3'h0;
        end else begin
            case (state)
                rcpm_pkg::RUN: begin
                    wake_pend <= 1'b0;
                    if (power_save_instruction) begin
                        wake_pend <= wake_evt;
                        state     <= (power_save_operand == `RCPM_OP_IDLE) ?
                                     rcpm_pkg::ENTER_IDLE : rcpm_pkg::ENTER_SLEEP;
                        sleep_osc <= osc_sel;
                    end
                end
                rcpm_pkg::ENTER_SLEEP: begin
                    state <= rcpm_pkg::SLEEP;
                end
                rcpm_pkg::ENTER_IDLE: begin
                    state <= rcpm_pkg::IDLE;
                end
                rcpm_pkg::SLEEP: begin
                    if (wake_evt || wake_pend) begin
                        wake_pend <= 1'b0;
                        if (!reset_control_reg[`RCPM_BIT_VREG_STBY]) begin
                            tvreg_cnt <= TVW'(TVREG_CY);
                            state     <= rcpm_pkg::WAKE_REG;
                        end else begin
                            state <= rcpm_pkg::RUN;
                        end
                    end
                end
                rcpm_pkg::IDLE: begin
                    if (wake_evt || wake_pend) begin
                        wake_pend <= 1'b0;
                        state     <= rcpm_pkg::RUN;
                    end
                end
                rcpm_pkg::WAKE_REG: begin
                    if (tvreg_cnt <= TVW'(1)) begin
                        state <= rcpm_pkg::RUN;
                    end else begin
                        tvreg_cnt <= tvreg_cnt - TVW'(1);
                    end
                end
                default: state <= rcpm_pkg::RUN;
            endcase
        end
    end

    // power outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_clk_run     <= 1'b1;
            primary_osc_run <= 1'b1;
            low_power_rc_oscillator_run        <= 1'b0;
            fail_safe_clock_monitor_active     <= 1'b0;
            cpu_run         <= 1'b1;
            periph_run      <= 1'b1;
            wdt_clear       <= 1'b0;
            vreg_standby    <= 1'b0;
            cpu_resume      <= 1'b0;
            active_osc      <= 3'h0;
        end else begin
            sys_clk_run     <= !in_sleep;
            primary_osc_run <= !in_sleep || pwr_cfg[`RCPM_BIT_PRIMARY_MODE]
                               || pwr_cfg[`RCPM_BIT_POSC_KEEP];
            low_power_rc_oscillator_run        <= pwr_cfg[`RCPM_BIT_WDT_EN]
                               || (!in_sleep && pwr_cfg[`RCPM_BIT_FAIL_SAFE_CLOCK_MONITOR_EN]);
            fail_safe_clock_monitor_active     <= pwr_cfg[`RCPM_BIT_FAIL_SAFE_CLOCK_MONITOR_EN] && !in_sleep;
            cpu_run         <= (state == rcpm_pkg::RUN);
            periph_run      <= !in_sleep && state != rcpm_pkg::WAKE_REG;
            wdt_clear       <= pwr_cfg[`RCPM_BIT_WDT_EN] &&
                               (state == rcpm_pkg::ENTER_SLEEP ||
                                state == rcpm_pkg::ENTER_IDLE);
            vreg_standby    <= in_sleep && !reset_control_reg[`RCPM_BIT_VREG_STBY];
            cpu_resume      <= (state == rcpm_pkg::IDLE || state == rcpm_pkg::SLEEP ||
                                state == rcpm_pkg::WAKE_REG) &&
                               (wake_evt || wake_pend);
            active_osc      <= (state == rcpm_pkg::RUN) ? osc_sel : sleep_osc;
        end
    end

endmodule : rcpm_refclk_power

// >>> rcpm_refclk_power_chk.sv
// Purpose: port checker for the reference clock and power block
// Assumes: bound to the top module; TVREG_CY of 4
// Notes:   shadows the control and power config registers
`timescale 1ns/1ps
`include "rcpm_regs.svh"
module rcpm_refclk_power_chk (
    // clock, reset, register port
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    // power save and wake
    input wire logic        power_save_instruction,
    input wire logic        power_save_operand,
    input wire logic        irq_wake,
    input wire logic        wdt_timeout,
    // outputs watched
    input wire logic        ref_clock_pin,
    input wire logic        ref_clock_pin_oe,
    input wire logic        sys_clk_run,
    input wire logic        primary_osc_run,
    input wire logic        low_power_rc_oscillator_run,
    input wire logic        cpu_run,
    input wire logic        wdt_clear,
    input wire logic        cpu_resume
);
    logic [4:0] cfg;
    logic       en;
    logic       slp;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= 5'h00;
        end else if (reg_wr && reg_addr == `RCPM_ADDR_PWRCFG) begin
            cfg <= reg_wdata[4:0];
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            en  <= 1'b0;
            slp <= 1'b0;
        end else if (reg_wr && reg_addr == `RCPM_ADDR_REFOCTL) begin
            en  <= reg_wdata[15];
            slp <= reg_wdata[13];
        end
    end
    sequence s_req; power_save_instruction && cpu_run; endsequence
    sequence s_quiet; !irq_wake && !wdt_timeout; endsequence
    sequence s_sleep; s_req ##0 !power_save_operand ##0 s_quiet ##1 s_quiet[*2]; endsequence
    property p_req_halt; s_req |-> ##2 !cpu_run; endproperty
    property p_wdt_clr; s_req ##1 1'b1 |=> wdt_clear == cfg[2]; endproperty
    property p_sleep_stop; s_sleep |=> !sys_clk_run && !cpu_run; endproperty
    property p_wake;
        (irq_wake || wdt_timeout) && !cpu_run && !cpu_resume && !$past(cpu_resume)
            |-> ##[1:12] cpu_resume;
    endproperty
    property p_oe; $stable(en) |-> ref_clock_pin_oe == en; endproperty
    property p_sleep_gate;
        !sys_clk_run && !$past(sys_clk_run) && !slp |-> !ref_clock_pin;
    endproperty
    property p_posc;
        !sys_clk_run && !$past(sys_clk_run) |-> primary_osc_run == (cfg[0] || cfg[1]);
    endproperty
    property p_low_power_rc_oscillator; !sys_clk_run && !$past(sys_clk_run) |-> low_power_rc_oscillator_run == cfg[2]; endproperty
    a_req_halt: assert property (p_req_halt) else $error("cpu kept running");
    a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog clear wrong");
    a_sleep_stop: assert property (p_sleep_stop) else $error("sleep clock not stopped");
    a_wake: assert property (p_wake) else $error("no wake");
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    a_sleep_gate: assert property (p_sleep_gate) else $error("pin runs in sleep");
    a_posc: assert property (p_posc) else $error("crystal state wrong");
    a_low_power_rc_oscillator: assert property (p_low_power_rc_oscillator) else $error("rc oscillator wrong");
endmodule : rcpm_refclk_power_chk

// >>> rcpm_ext_dev.sv
// Purpose: external device clocked from the reference pin
// Assumes: pin pulled low while undriven
// Notes:   counts rising edges and the last period in ref_clk cycles
`timescale 1ns/1ps
module rcpm_ext_dev (
    // clock and pin
    input  wire logic ref_clk,
    input  wire logic ref_clock_pin,
    input  wire logic ref_clock_pin_oe,
    // measurements
    output int        rises,
    output int        period
);
    logic lvl_d = 1'b0;
    int   cnt   = 0;
    wire  lvl   = ref_clock_pin_oe ? ref_clock_pin : 1'b0;
    initial rises = 0;
    initial period = 0;
    always @(posedge ref_clk) begin
        lvl_d <= lvl;
        cnt   <= cnt + 1;
        if (lvl && !lvl_d) begin
            rises  <= rises + 1;
            period <= cnt;
            cnt    <= 1;
        end
    end
endmodule : rcpm_ext_dev

// >>> rcpm_refclk_power_bench.sv
// Purpose: self-checking bench for the reference clock and power block
// Assumes: base clocks of 8 and 16 ref_clk cycles
// Notes:   regulator wait shortened to 4 cycles
`timescale 1ns/1ps
`include "rcpm_regs.svh"
module rcpm_refclk_power_bench;
    logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, sys_clk_in = 0, primary_osc_in = 0;
    logic power_save_instruction = 0, power_save_operand = 0, irq_wake = 0, wdt_timeout = 0;
    logic [3:0] reg_addr = 4'h0, cnt = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [2:0] new_oscillator_select = 3'h0;
    logic [15:0] reg_rdata;
    logic [2:0] active_osc;
    logic ref_clock_pin, ref_clock_pin_oe, sys_clk_run, primary_osc_run, low_power_rc_oscillator_run, fail_safe_clock_monitor_active;
    logic cpu_run, periph_run, wdt_clear, vreg_standby, cpu_resume, vsel = 0;
    int err_count = 0, total_checks = 0, rises, period;
    rcpm_refclk_power #(.TVREG_CY(4)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_clk_in(sys_clk_in),
        .primary_osc_in(primary_osc_in), .power_save_instruction(power_save_instruction),
        .power_save_operand(power_save_operand), .irq_wake(irq_wake),
        .wdt_timeout(wdt_timeout), .new_oscillator_select(new_oscillator_select),
        .ref_clock_pin(ref_clock_pin), .ref_clock_pin_oe(ref_clock_pin_oe),
        .sys_clk_run(sys_clk_run), .primary_osc_run(primary_osc_run), .low_power_rc_oscillator_run(low_power_rc_oscillator_run),
        .fail_safe_clock_monitor_active(fail_safe_clock_monitor_active), .cpu_run(cpu_run), .periph_run(periph_run),
        .wdt_clear(wdt_clear), .vreg_standby(vreg_standby), .cpu_resume(cpu_resume),
        .active_osc(active_osc));
    rcpm_ext_dev ext (.ref_clk(ref_clk), .ref_clock_pin(ref_clock_pin),
        .ref_clock_pin_oe(ref_clock_pin_oe), .rises(rises), .period(period));
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cnt <= cnt + 4'h1;
        sys_clk_in <= cnt[2];
        primary_osc_in <= cnt[3];
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge ref_clk); reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge ref_clk); reg_rd <= 1'b0;
        @(negedge ref_clk); chk("reg_rdata", exp, reg_rdata);
    endtask : rd
    task automatic t_div(input logic sel, input logic [3:0] dv, input logic [15:0] per);
        int n;
        wr(`RCPM_ADDR_REFOCTL, {1'b1, 2'b00, sel, dv, 8'h00});
        n = rises;
        for (int i = 0; i < 3000 && rises < n + 3; i++) @(posedge ref_clk);
        chk("period", per, period[15:0]);
    endtask : t_div
    task automatic t_ps(input logic op, input logic [4:0] cf, input logic out);
        logic [2:0] sv;
        int n;
        wr(`RCPM_ADDR_PWRCFG, {11'h000, cf});
        sv = new_oscillator_select;
        @(posedge ref_clk); power_save_instruction <= 1'b1; power_save_operand <= op;
        @(posedge ref_clk); power_save_instruction <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk); chk("wdt_clear", cf[2], wdt_clear);
        repeat (11) @(posedge ref_clk);
        n = rises;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("cpu_run", 0, cpu_run);
        chk("sys_clk_run", op, sys_clk_run);
        chk("periph_run", op, periph_run);
        chk("primary_osc_run", op | cf[0] | cf[1], primary_osc_run);
        chk("low_power_rc_oscillator_run", op ? cf[2] | cf[3] : cf[2], low_power_rc_oscillator_run);
        chk("fail_safe_clock_monitor_active", op & cf[3], fail_safe_clock_monitor_active);
        chk("vreg_standby", !op && !vsel, vreg_standby);
        chk("active_osc", sv, active_osc);
        chk("ref_out_moving", out, rises != n);
        @(posedge ref_clk); irq_wake <= op; wdt_timeout <= !op;
        @(posedge ref_clk); irq_wake <= 1'b0; wdt_timeout <= 1'b0;
        @(negedge ref_clk); chk("cpu_resume", 1, cpu_resume);
        for (int i = 0; i < 40 && cpu_run !== 1'b1; i++) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("cpu_run", 1, cpu_run);
        chk("active_osc", sv, active_osc);
    endtask : t_ps
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(`RCPM_ADDR_REFOCTL, `RCPM_REFOCTL_RESET);
        rd(`RCPM_ADDR_RESETCTL, `RCPM_RESETCTL_RESET);
        wr(`RCPM_ADDR_REFOCTL, 16'hffff);
        rd(`RCPM_ADDR_REFOCTL, `RCPM_REFOCTL_MASK);
        rd(4'h9, 16'h0000);
        t_div(1'b0, 4'h0, 16'h0008);
        t_div(1'b0, 4'h1, 16'h0010);
        t_div(1'b0, 4'h3, 16'h0040);
        t_div(1'b1, 4'h1, 16'h0020);
        new_oscillator_select <= 3'h5;
        wr(`RCPM_ADDR_PWRCFG, 16'h0010);
        new_oscillator_select <= 3'h2;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk); chk("active_osc", 3'h5, active_osc);
        wr(`RCPM_ADDR_REFOCTL, 16'h8000);
        t_ps(1'b0, 5'h04, 1'b0);
        wr(`RCPM_ADDR_RESETCTL, 16'h0100);
        vsel = 1'b1;
        wr(`RCPM_ADDR_REFOCTL, 16'hb000);
        t_ps(1'b0, 5'h03, 1'b1);
        t_ps(1'b1, 5'h0c, 1'b1);
        @(posedge ref_clk); power_save_instruction <= 1'b1; power_save_operand <= 1'b0;
        irq_wake <= 1'b1;
        @(posedge ref_clk); power_save_instruction <= 1'b0; irq_wake <= 1'b0;
        repeat (30) @(posedge ref_clk);
        @(negedge ref_clk); chk("cpu_run", 1, cpu_run);
        close_out;
    end
endmodule : rcpm_refclk_power_bench
bind rcpm_refclk_power rcpm_refclk_power_chk chk_i (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .power_save_instruction(power_save_instruction),
    .power_save_operand(power_save_operand), .irq_wake(irq_wake), .wdt_timeout(wdt_timeout),
    .ref_clock_pin(ref_clock_pin), .ref_clock_pin_oe(ref_clock_pin_oe),
    .sys_clk_run(sys_clk_run), .primary_osc_run(primary_osc_run), .low_power_rc_oscillator_run(low_power_rc_oscillator_run),
    .cpu_run(cpu_run), .wdt_clear(wdt_clear), .cpu_resume(cpu_resume));
